// ==== tkc_cfg.svh ====
`ifndef TKC_CFG_SVH
`define TKC_CFG_SVH

// register byte offsets
`define TKC_OFS_DIAG_CTRL    5'h00
`define TKC_OFS_FRAME_STAT   5'h04
`define TKC_OFS_MODE_STAT    5'h08
`define TKC_OFS_IRQ          5'h0c
`define TKC_OFS_NET_CTRL     5'h10
`define TKC_OFS_BUF_CFG      5'h14

// diag_control fields
`define TKC_DC_GO            0
`define TKC_DC_RAM           1
`define TKC_DC_LOOP          2
`define TKC_DC_XFER          3
`define TKC_DC_ADDR_DRV      4
`define TKC_DC_DIAG          7

// frame_engine_status fields
`define TKC_FS_SZ_LO         0
`define TKC_FS_HDR           5
`define TKC_FS_ACK           6
`define TKC_FS_LAST          7

// mode status, irq and network control fields
`define TKC_MS_STATE         1
`define TKC_IR_MODE          0
`define TKC_NC_ISOLATE       0
`define TKC_NC_MASK          1
`define TKC_NC_PIGGY         6
`define TKC_NC_TXEN          7
`define TKC_NC_LIM_LO        8

// reset values and frame constants
`define TKC_RST_BYTE         8'h00
`define TKC_RST_LIMIT        8'h01
`define TKC_HDR_LEN          16'h0008
`define TKC_BUF_UNIT_LOG2    6
`define TKC_MAX_BUFS         5'h10
`endif

// ==== tkc_pkg.sv ====
package tkc_pkg;

    typedef enum logic [0:0] {
        TKC_ISOLATE = 1'b0,
        TKC_DIAG    = 1'b1
    } tkc_mode_t;

    typedef enum logic [2:0] {
        TKC_DS_IDLE = 3'b000,
        TKC_DS_RAM  = 3'b001,
        TKC_DS_LOOP = 3'b010,
        TKC_DS_XFER = 3'b011,
        TKC_DS_DONE = 3'b100
    } tkc_dseq_t;

endpackage : tkc_pkg

// ==== tkc_diag_seq.sv ====
`timescale 1ns/1ns

module tkc_diag_seq
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // control
    input  wire logic start,
    input  wire logic ram_sel,
    input  wire logic loop_sel,
    input  wire logic xfer_sel,
    // test engines
    output logic      ram_test_go,
    output logic      loop_test_go,
    output logic      xfer_test_go,
    input  wire logic ram_test_done,
    input  wire logic loop_test_done,
    input  wire logic xfer_test_done,
    // status
    output logic      busy,
    output logic      done
);

    tkc_pkg::tkc_dseq_t state_r;
    tkc_pkg::tkc_dseq_t state_nxt;

    // --------------------------------------------------------------
    // sequence: selected tests one after another
    // --------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            tkc_pkg::TKC_DS_IDLE:
                if (start)
                    state_nxt = ram_sel  ? tkc_pkg::TKC_DS_RAM  :
                                loop_sel ? tkc_pkg::TKC_DS_LOOP :
                                xfer_sel ? tkc_pkg::TKC_DS_XFER :
                                           tkc_pkg::TKC_DS_DONE;
            tkc_pkg::TKC_DS_RAM:
                if (ram_test_done)
                    state_nxt = loop_sel ? tkc_pkg::TKC_DS_LOOP :
                                xfer_sel ? tkc_pkg::TKC_DS_XFER :
                                           tkc_pkg::TKC_DS_DONE;
            tkc_pkg::TKC_DS_LOOP:
                if (loop_test_done)
                    state_nxt = xfer_sel ? tkc_pkg::TKC_DS_XFER :
                                           tkc_pkg::TKC_DS_DONE;
            tkc_pkg::TKC_DS_XFER:
                if (xfer_test_done)
                    state_nxt = tkc_pkg::TKC_DS_DONE;
            tkc_pkg::TKC_DS_DONE:
                state_nxt = tkc_pkg::TKC_DS_IDLE;
            default:
                state_nxt = tkc_pkg::TKC_DS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            state_r <= tkc_pkg::TKC_DS_IDLE;
        else
            state_r <= state_nxt;
    end

    assign ram_test_go  = (state_r == tkc_pkg::TKC_DS_RAM);
    assign loop_test_go = (state_r == tkc_pkg::TKC_DS_LOOP);
    assign xfer_test_go = (state_r == tkc_pkg::TKC_DS_XFER);
    assign busy         = (state_r != tkc_pkg::TKC_DS_IDLE);
    assign done         = (state_r == tkc_pkg::TKC_DS_DONE);

endmodule : tkc_diag_seq

// ==== tkc_ctrl.sv ====
// Behaviour
// - go bit runs selected diagnostics, device clears it when finished.
// - ram select adds internal ram test to the diagnostic run.
// - loop select adds loop test to the diagnostic run.
// - transfer select adds dma test to the diagnostic run.
// - address outputs float unless drive enable set or dma ack low.
// - diag enable requests diagnostic mode; state bit confirms entry.
// - diagnostic bit meanings apply only when enable and state both set; the address drive bit acts here in any mode.
// - clearing diag enable lets running tests finish, then isolate.
// - leaving diagnostic mode for isolate raises mode change event.
// - buffer size is (code + 1) times 64 bytes, 64 to 1024.
// - buffer size sets link boundaries; at most 16 buffers per frame.
// - header-only flag set when transmitted frame length equals eight.
// - header-only means empty data frame, or scan frame if transparent.
// - ack pending flag set when received data frame needs ack/nak.
// - ack pending flag cleared once acknowledgement frame is sent.
// - final flag set on isolate, tx disable, block last, limit, underrun.
// - end of transmit queue never sets the final flag.
// - piggyback enabled and no ack requested appends token to last frame; here only when block last or limit set the final flag.
// - final flag holds until next data frame transmission starts.
// - unmasked mode change requests interrupt; reading irq reg clears all.
//
// Chosen here: register access over Avalon-MM and the register offsets.
`include "tkc_cfg.svh"
`timescale 1ns/1ns

module tkc_ctrl
#(
    parameter int ADDR_W = 16
)
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    // avalon-mm slave
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [3:0]        avs_byteenable,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // interrupt request
    output logic                   irq,
    // dma address pins
    input  wire logic [ADDR_W-1:0] dma_addr_in,
    input  wire logic              dma_ack_n,
    output logic [ADDR_W-1:0]      dma_addr_o,
    output logic                   dma_addr_oe,
    // transmit engine
    input  wire logic              tx_frame_start,
    input  wire logic              tx_frame_end,
    input  wire logic [15:0]       tx_frame_len,
    input  wire logic              tx_transparent,
    input  wire logic              tx_ctl_block_last,
    input  wire logic              tx_underrun,
    input  wire logic              tx_ack_req,
    input  wire logic              token_rcvd,
    output logic                   token_append,
    output logic                   scan_frame,
    // receive engine
    input  wire logic              rx_ack_needed,
    input  wire logic              ack_tx_done,
    // buffer linking
    input  wire logic              dma_byte,
    output logic                   buf_boundary,
    output logic                   buf_overflow,
    output logic [10:0]            buf_bytes,
    // diagnostic test engines
    output logic                   ram_test_go,
    output logic                   loop_test_go,
    output logic                   xfer_test_go,
    input  wire logic              ram_test_done,
    input  wire logic              loop_test_done,
    input  wire logic              xfer_test_done
);

    // --------------------------------------------------------------
    // storage
    // --------------------------------------------------------------
    logic [7:0]          diag_ctrl_r;
    logic [15:0]         net_ctrl_r;
    logic [3:0]          buf_size_code;
    tkc_pkg::tkc_mode_t  mode_r;
    logic                mode_change_irq;
    logic                header_only_flag;
    logic                ack_pending_flag;
    logic                final_frame_flag;
    logic                final_by_req;
    logic                tx_active_r;
    logic [7:0]          frame_cnt_r;
    logic                ack_r;
    logic [31:0]         rdata_r;
    logic [1:0]          ack_sync_r;
    logic [ADDR_W-1:0]   addr_r;
    logic [10:0]         byte_cnt_r;
    logic [4:0]          buf_idx_r;
    logic                token_append_r;
    logic                buf_boundary_r;
    logic                buf_overflow_r;

    logic                acc;
    logic                wr_done;
    logic                rd_sample;
    logic                diag_active;
    logic                seq_busy;
    logic                seq_done;
    logic                isolate_req;
    logic                irq_mask_bit;
    logic                piggy_en;
    logic                tx_enable_bit;
    logic [7:0]          token_frame_limit;
    logic                limit_hit;
    logic                final_cause;
    logic                req_cause;
    logic                boundary;

    // --------------------------------------------------------------
    // bus handshake: one wait state per access
    // --------------------------------------------------------------
    assign acc             = avs_read | avs_write;
    assign avs_waitrequest = acc & ~ack_r;
    assign wr_done         = avs_write & ack_r;
    assign rd_sample       = avs_read & ~ack_r;
    assign avs_readdata    = rdata_r;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            ack_r <= 1'b0;
        else
            ack_r <= acc & ~ack_r;
    end

    // reads sample state at the first edge; no clear happens here
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            rdata_r <= 32'h0000_0000;
        else if (rd_sample)
        begin
            rdata_r <= 32'h0000_0000;
            case (avs_address)
                `TKC_OFS_DIAG_CTRL:
                    rdata_r[7:0] <= diag_ctrl_r;
                `TKC_OFS_FRAME_STAT:
                begin
                    rdata_r[`TKC_FS_SZ_LO+3:`TKC_FS_SZ_LO] <= buf_size_code;
                    rdata_r[`TKC_FS_HDR]  <= header_only_flag;
                    rdata_r[`TKC_FS_ACK]  <= ack_pending_flag;
                    rdata_r[`TKC_FS_LAST] <= final_frame_flag;
                end
                `TKC_OFS_MODE_STAT:
                    rdata_r[`TKC_MS_STATE] <= (mode_r == tkc_pkg::TKC_DIAG);
                `TKC_OFS_IRQ:
                    rdata_r[`TKC_IR_MODE] <= mode_change_irq;
                `TKC_OFS_NET_CTRL:
                    rdata_r[15:0] <= net_ctrl_r;
                `TKC_OFS_BUF_CFG:
                    rdata_r[3:0] <= buf_size_code;
                default:
                    rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // --------------------------------------------------------------
    // diagnostic control register
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            diag_ctrl_r <= `TKC_RST_BYTE;
        else if (wr_done && avs_address == `TKC_OFS_DIAG_CTRL
                 && avs_byteenable[0])
        begin
            diag_ctrl_r[`TKC_DC_GO]   <= avs_writedata[`TKC_DC_GO]
                | (diag_ctrl_r[`TKC_DC_GO] & ~seq_done);
            diag_ctrl_r[`TKC_DC_XFER:`TKC_DC_RAM]
                <= avs_writedata[`TKC_DC_XFER:`TKC_DC_RAM];
            diag_ctrl_r[`TKC_DC_ADDR_DRV] <= avs_writedata[`TKC_DC_ADDR_DRV];
            diag_ctrl_r[`TKC_DC_DIAG] <= avs_writedata[`TKC_DC_DIAG];
        end
        else if (seq_done)
            diag_ctrl_r[`TKC_DC_GO] <= 1'b0;
    end

    // --------------------------------------------------------------
    // network control and buffer size registers
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            net_ctrl_r    <= {`TKC_RST_LIMIT, `TKC_RST_BYTE};
            buf_size_code <= 4'h0;
        end
        else if (wr_done)
        begin
            if (avs_address == `TKC_OFS_NET_CTRL)
            begin
                if (avs_byteenable[0])
                    net_ctrl_r[7:0] <= avs_writedata[7:0];
                if (avs_byteenable[1])
                    net_ctrl_r[15:8] <= avs_writedata[15:8];
            end
            if (avs_address == `TKC_OFS_BUF_CFG && avs_byteenable[0])
                buf_size_code <= avs_writedata[3:0];
        end
    end

    assign isolate_req       = net_ctrl_r[`TKC_NC_ISOLATE];
    assign irq_mask_bit      = net_ctrl_r[`TKC_NC_MASK];
    assign piggy_en          = net_ctrl_r[`TKC_NC_PIGGY];
    assign tx_enable_bit     = net_ctrl_r[`TKC_NC_TXEN];
    assign token_frame_limit = net_ctrl_r[`TKC_NC_LIM_LO+7:`TKC_NC_LIM_LO];

    // --------------------------------------------------------------
    // mode state machine
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            mode_r <= tkc_pkg::TKC_ISOLATE;
        else
            case (mode_r)
                tkc_pkg::TKC_ISOLATE:
                    if (diag_ctrl_r[`TKC_DC_DIAG])
                        mode_r <= tkc_pkg::TKC_DIAG;
                tkc_pkg::TKC_DIAG:
                    if (!diag_ctrl_r[`TKC_DC_DIAG] && !seq_busy)
                        mode_r <= tkc_pkg::TKC_ISOLATE;
                default:
                    mode_r <= tkc_pkg::TKC_ISOLATE;
            endcase
    end

    assign diag_active = diag_ctrl_r[`TKC_DC_DIAG]
                       & (mode_r == tkc_pkg::TKC_DIAG);

    // --------------------------------------------------------------
    // interrupt register: set beats read-clear
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            mode_change_irq <= 1'b0;
        else if (mode_r == tkc_pkg::TKC_DIAG && !diag_ctrl_r[`TKC_DC_DIAG]
                 && !seq_busy)
            mode_change_irq <= 1'b1;
        else if (rd_sample && avs_address == `TKC_OFS_IRQ)
            mode_change_irq <= 1'b0;
    end

    assign irq = mode_change_irq & ~irq_mask_bit;

    // --------------------------------------------------------------
    // diagnostic sequencer
    // --------------------------------------------------------------
    tkc_diag_seq u_seq
    (
        .ref_clk        (ref_clk),
        .nrst           (nrst),
        .start          (diag_active & diag_ctrl_r[`TKC_DC_GO]),
        .ram_sel        (diag_ctrl_r[`TKC_DC_RAM]),
        .loop_sel       (diag_ctrl_r[`TKC_DC_LOOP]),
        .xfer_sel       (diag_ctrl_r[`TKC_DC_XFER]),
        .ram_test_go    (ram_test_go),
        .loop_test_go   (loop_test_go),
        .xfer_test_go   (xfer_test_go),
        .ram_test_done  (ram_test_done),
        .loop_test_done (loop_test_done),
        .xfer_test_done (xfer_test_done),
        .busy           (seq_busy),
        .done           (seq_done)
    );

    // --------------------------------------------------------------
    // dma address outputs
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ack_sync_r  <= 2'b11;
            addr_r      <= '0;
        end
        else
        begin
            ack_sync_r  <= {ack_sync_r[0], dma_ack_n};
            addr_r      <= dma_addr_in;
        end
    end

    assign dma_addr_o  = addr_r;
    assign dma_addr_oe = diag_ctrl_r[`TKC_DC_ADDR_DRV]
                       | ~ack_sync_r[1];

    // --------------------------------------------------------------
    // transmit flags
    // --------------------------------------------------------------
    assign limit_hit   = (frame_cnt_r + 8'h01 >= token_frame_limit);
    assign req_cause   = tx_ctl_block_last | limit_hit;
    // queue end is not a cause here
    assign final_cause = tx_active_r & (isolate_req | ~tx_enable_bit
                       | req_cause | tx_underrun);

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            tx_active_r <= 1'b0;
        else if (tx_frame_start)
            tx_active_r <= 1'b1;
        else if (tx_frame_end)
            tx_active_r <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            frame_cnt_r <= 8'h00;
        else if (token_rcvd)
            frame_cnt_r <= 8'h00;
        else if (tx_frame_end)
            frame_cnt_r <= frame_cnt_r + 8'h01;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            header_only_flag <= 1'b0;
        else if (tx_frame_start)
            header_only_flag <= (tx_frame_len == `TKC_HDR_LEN);
    end

    assign scan_frame = header_only_flag & tx_transparent;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            final_frame_flag <= 1'b0;
            final_by_req     <= 1'b0;
        end
        else if (final_cause)
        begin
            final_frame_flag <= 1'b1;
            final_by_req     <= final_by_req | (req_cause & ~tx_underrun);
        end
        else if (tx_frame_start)
        begin
            final_frame_flag <= 1'b0;
            final_by_req     <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            token_append_r <= 1'b0;
        else
            token_append_r <= tx_frame_end & final_frame_flag & final_by_req
                            & piggy_en & ~tx_ack_req;
    end

    assign token_append = token_append_r;

    // --------------------------------------------------------------
    // receive acknowledgement flag: set beats clear
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            ack_pending_flag <= 1'b0;
        else if (rx_ack_needed)
            ack_pending_flag <= 1'b1;
        else if (ack_tx_done)
            ack_pending_flag <= 1'b0;
    end

    // --------------------------------------------------------------
    // buffer boundary tracking
    // --------------------------------------------------------------
    assign buf_bytes = {7'h00, buf_size_code}
                     + 11'h001 << `TKC_BUF_UNIT_LOG2;
    assign boundary  = dma_byte & (byte_cnt_r + 11'h001 == buf_bytes);

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            byte_cnt_r     <= 11'h000;
            buf_idx_r      <= 5'h00;
            buf_boundary_r <= 1'b0;
            buf_overflow_r <= 1'b0;
        end
        else if (tx_frame_start)
        begin
            byte_cnt_r     <= 11'h000;
            buf_idx_r      <= 5'h00;
            buf_boundary_r <= 1'b0;
            buf_overflow_r <= 1'b0;
        end
        else
        begin
            buf_boundary_r <= boundary;
            if (boundary)
            begin
                byte_cnt_r <= 11'h000;
                buf_idx_r  <= buf_idx_r + 5'h01;
            end
            else if (dma_byte)
                byte_cnt_r <= byte_cnt_r + 11'h001;
            if (dma_byte && buf_idx_r == `TKC_MAX_BUFS)
                buf_overflow_r <= 1'b1;
        end
    end

    assign buf_boundary = buf_boundary_r;
    assign buf_overflow = buf_overflow_r;

endmodule : tkc_ctrl

// ==== tkc_ctrl_properties.sv ====
`timescale 1ns/1ns

module tkc_ctrl_props
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        nrst,
    // watched ports
    input wire logic        avs_read,
    input wire logic        avs_waitrequest,
    input wire logic        dma_ack_n,
    input wire logic        dma_addr_oe,
    input wire logic        tx_frame_end,
    input wire logic        tx_transparent,
    input wire logic        token_append,
    input wire logic        scan_frame,
    input wire logic [10:0] buf_bytes,
    input wire logic        ram_test_go,
    input wire logic        loop_test_go,
    input wire logic        xfer_test_go,
    input wire logic        ram_test_done
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ----
    // checks
    // ----
    a_oe_ack_low: assert property (!dma_ack_n [*3] |-> dma_addr_oe)
        else $error("address pins float under dma ack");
    a_tests_one: assert property
        ($onehot0({ram_test_go, loop_test_go, xfer_test_go}))
        else $error("two tests run at once");
    a_ram_stop: assert property
        (ram_test_go && ram_test_done |=> !ram_test_go)
        else $error("ram test runs on after done");
    a_tok_after_end: assert property
        (token_append |-> $past(tx_frame_end))
        else $error("token appended without frame end");
    a_tok_pulse: assert property (token_append |=> !token_append)
        else $error("token append longer than one cycle");
    a_scan_transp: assert property (scan_frame |-> tx_transparent)
        else $error("scan frame outside transparent mode");
    a_buf_range: assert property
        (buf_bytes inside {[11'h040:11'h400]} && buf_bytes[5:0] == 6'h00)
        else $error("buffer size off the 64 byte grid");
    a_bus_one_wait: assert property
        (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read held in wait too long");
    c_xfer: cover property ($rose(xfer_test_go));
    c_token: cover property (token_append);
    c_scan: cover property (scan_frame);
endmodule : tkc_ctrl_props

bind tkc_ctrl tkc_ctrl_props tkc_ctrl_props_i (.ref_clk(ref_clk),
    .nrst(nrst), .avs_read(avs_read), .avs_waitrequest(avs_waitrequest),
    .dma_ack_n(dma_ack_n), .dma_addr_oe(dma_addr_oe),
    .tx_frame_end(tx_frame_end), .tx_transparent(tx_transparent),
    .token_append(token_append), .scan_frame(scan_frame),
    .buf_bytes(buf_bytes), .ram_test_go(ram_test_go),
    .loop_test_go(loop_test_go), .xfer_test_go(xfer_test_go),
    .ram_test_done(ram_test_done));

// ==== tkc_test_engines.sv ====
`timescale 1ns/1ns

module tkc_test_engines
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // engine handshake
    input  wire logic [7:0] lat,
    input  wire logic [2:0] go,
    output logic      [2:0] done
);
    logic [7:0] cnt_r [3];
    // ----
    // each engine pulses done lat + 1 cycles after its go rises
    // ----
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!nrst)
            begin
                cnt_r[i] <= 8'h00;
                done[i]  <= 1'b0;
            end
            else
            begin
                cnt_r[i] <= go[i] ? cnt_r[i] + 8'h01 : 8'h00;
                done[i]  <= go[i] && cnt_r[i] == lat;
            end
        end
    end
endmodule : tkc_test_engines

// ==== tkc_ctrl_bench.sv ====
`include "tkc_cfg.svh"
`timescale 1ns/1ns

module tkc_ctrl_bench;
    logic        ref_clk = 0, nrst = 0, avs_read = 0, avs_write = 0;
    logic [4:0]  avs_address = '0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = '0, avs_readdata, rd;
    logic        avs_waitrequest, irq, dma_ack_n = 1, dma_addr_oe, w, tok;
    logic [15:0] dma_addr_in = '0, dma_addr_o, tx_frame_len = '0, len;
    logic        tx_frame_start = 0, tx_frame_end = 0, tx_transparent = 0;
    logic        tx_ctl_block_last = 0, tx_underrun = 0, tx_ack_req = 0;
    logic        token_rcvd = 0, token_append, scan_frame, dma_byte = 0;
    logic        rx_ack_needed = 0, ack_tx_done = 0, buf_boundary;
    logic        buf_overflow, ram_test_go, loop_test_go, xfer_test_go;
    logic [10:0] buf_bytes;
    wire         ram_test_done, loop_test_done, xfer_test_done;
    logic [7:0]  lat = 8'h00;
    logic [3:0]  code;
    logic [2:0]  seen;
    int          compares = 0, miscompares = 0, k;

    tkc_ctrl tkc_ctrl_i (.*);
    tkc_test_engines tkc_test_engines_i (.ref_clk(ref_clk), .nrst(nrst),
        .lat(lat), .go({xfer_test_go, loop_test_go, ram_test_go}),
        .done({xfer_test_done, loop_test_done, ram_test_done}));

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        dma_addr_in <= 16'($urandom);
        dma_byte    <= 1'($urandom);
    end
    always @(negedge ref_clk)
    begin
        seen = seen | {xfer_test_go, loop_test_go, ram_test_go};
        tok  = tok | token_append;
    end
    // ----
    // helpers
    // ----
    task finish_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do
        begin
            @(negedge ref_clk);
            w  = avs_waitrequest;
            rd = avs_readdata;
            @(posedge ref_clk);
            n++;
        end
        while (w !== 1'b0 && n < 20);
        avs_write <= 0;
        avs_read  <= 0;
        @(posedge ref_clk);
        if (w !== 1'b0)
        begin
            miscompares++;
            finish_test;
        end
    endtask : bus

    task frame(input logic [15:0] l, input logic fl);
        tx_frame_len   <= l;
        tx_ctl_block_last <= fl;
        tx_transparent <= 1'($urandom);
        tx_frame_start <= 1;
        @(posedge ref_clk);
        tx_frame_start <= 0;
        repeat (3) @(posedge ref_clk);
        tx_frame_end <= 1;
        @(posedge ref_clk);
        tx_frame_end <= 0;
        repeat (2) @(posedge ref_clk);
    endtask : frame

    function logic [31:0] fs(input logic l, input logic a, input logic h);
        return {24'h0, l, a, h, 1'b0, code};
    endfunction : fs
    // ----
    // tests
    // ----
    initial
    begin
        void'($urandom(77));
        code = 4'($urandom);
        repeat (3) @(posedge ref_clk);
        nrst <= 1;
        @(posedge ref_clk);
        bus(0, `TKC_OFS_FRAME_STAT, 0);
        chk(rd, 0);
        bus(0, 5'h1c, 0);
        chk(rd, 0);
        bus(1, `TKC_OFS_BUF_CFG, {28'h0, code});
        bus(0, `TKC_OFS_FRAME_STAT, 0);
        chk(rd, fs(0, 0, 0));
        chk(buf_bytes, (32'(code) + 1) << 6);
        $display("registers done");
        bus(1, `TKC_OFS_DIAG_CTRL, 32'h80);
        bus(0, `TKC_OFS_MODE_STAT, 0);
        chk(rd[1], 1);
        for (int s = 0; s < 8; s++)
        begin
            lat <= 8'($urandom % 12);
            seen = 0;
            bus(1, `TKC_OFS_DIAG_CTRL, 32'h81 | (s << 1));
            k = 0;
            do
            begin
                bus(0, `TKC_OFS_DIAG_CTRL, 0);
                k++;
            end
            while (rd[0] !== 1'b0 && k < 30);
            chk(rd[0], 0);
            chk(seen, s);
        end
        bus(1, `TKC_OFS_DIAG_CTRL, 0);
        bus(0, `TKC_OFS_MODE_STAT, 0);
        chk(rd[1], 0);
        chk(irq, 1);
        bus(0, `TKC_OFS_IRQ, 0);
        chk(rd[0], 1);
        @(negedge ref_clk);
        chk(irq, 0);
        @(posedge ref_clk);
        bus(0, `TKC_OFS_IRQ, 0);
        chk(rd[0], 0);
        $display("diagnostics done");
        bus(1, `TKC_OFS_DIAG_CTRL, 32'h10);
        @(negedge ref_clk);
        chk(dma_addr_oe, 1);
        @(posedge ref_clk);
        bus(1, `TKC_OFS_DIAG_CTRL, 0);
        @(negedge ref_clk);
        chk(dma_addr_oe, 0);
        @(posedge ref_clk);
        dma_ack_n <= 0;
        repeat (3) @(negedge ref_clk);
        chk(dma_addr_oe, 1);
        @(posedge ref_clk);
        dma_ack_n <= 1;
        $display("address pins done");
        bus(1, `TKC_OFS_NET_CTRL, 32'hffc0);
        for (int f = 0; f < 3; f++)
        begin
            tok = 0;
            len = (f == 0) ? 16'h0008 : 16'(9 + $urandom % 500);
            frame(len, f == 1);
            @(negedge ref_clk);
            chk(scan_frame, (f == 0) & tx_transparent);
            chk(tok, f == 1);
            @(posedge ref_clk);
            bus(0, `TKC_OFS_FRAME_STAT, 0);
            chk(rd, fs(f == 1, 0, f == 0));
        end
        rx_ack_needed <= 1;
        @(posedge ref_clk);
        rx_ack_needed <= 0;
        bus(0, `TKC_OFS_FRAME_STAT, 0);
        chk(rd, fs(0, 1, 0));
        ack_tx_done <= 1;
        @(posedge ref_clk);
        ack_tx_done <= 0;
        bus(0, `TKC_OFS_FRAME_STAT, 0);
        chk(rd, fs(0, 0, 0));
        $display("frames done");
        finish_test;
    end
endmodule : tkc_ctrl_bench
